// file: pkg/jtc_pkg.sv
// Constants, register map and carrier types of the transmit link configuration block.
// Notes on behaviour
// - Three-bit link test selector, three codes reserved.
// - SYSREF loads multiframe phase counter with offset.
// - Eight-bit device identifier, reset zero, sent.
// - Four-bit bank identifier, reset zero, sent.
// - Four five-bit lane identifiers, reset 0..3.
// - Bit 7 enables scrambler, set after reset.
// - Lane code 0,1,3 gives 1,2,4 lanes.
// - Octets per frame is field plus one.
// - Frames per multiframe is field plus one.
package jtc_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [11:0] IDX_LINK_TEST = 12'h574;
   localparam logic [11:0] IDX_PHASE_OFS = 12'h578;
   localparam logic [11:0] IDX_DEV_ID = 12'h580;
   localparam logic [11:0] IDX_BANK_ID = 12'h581;
   localparam logic [11:0] IDX_LANE0_ID = 12'h583;
   localparam logic [11:0] IDX_LANE1_ID = 12'h584;
   localparam logic [11:0] IDX_LANE2_ID = 12'h585;
   localparam logic [11:0] IDX_LANE3_ID = 12'h586;
   localparam logic [11:0] IDX_SCR_LANES = 12'h58B;
   localparam logic [11:0] IDX_FRAME_OCT = 12'h58C;
   localparam logic [11:0] IDX_MF_FRAMES = 12'h58D;

   // Field positions and lane count.
   localparam int SCR_BIT = 7;
   localparam int NUM_LANES = 4;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_MSB = 13;

   // Reset values.
   localparam logic [2:0] RST_LINK_TEST = 3'h0;
   localparam logic [4:0] RST_PHASE_OFS = 5'h00;
   localparam logic [7:0] RST_DEV_ID = 8'h00;
   localparam logic [3:0] RST_BANK_ID = 4'h0;
   localparam logic [4:0] RST_LANE_ID [NUM_LANES] = '{5'h00, 5'h01, 5'h02, 5'h03};
   localparam logic RST_SCR = 1'b1;
   localparam logic [4:0] RST_LANE_CODE = 5'h03;
   localparam logic [7:0] RST_FRAME_OCT = 8'h00;
   localparam logic [4:0] RST_MF_FRAMES = 5'h1F;

   // Lane count codes.
   localparam logic [4:0] LANES_ONE = 5'h00;
   localparam logic [4:0] LANES_TWO = 5'h01;
   localparam logic [4:0] LANES_FOUR = 5'h03;

   // Octets carried per lane in one core clock, and the sync depth for SYSREF.
   localparam int OCTETS_PER_CLK = 4;
   localparam int SYNC_STAGES = 3;

   // AHB-Lite transfer types and word transfer size.
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [2:0] {
      JTC_TEST_NORMAL = 3'b000,
      JTC_TEST_D21_5 = 3'b001,
      JTC_TEST_RPAT = 3'b100,
      JTC_TEST_JSPAT = 3'b101,
      JTC_TEST_JTSPAT = 3'b110
   } jtc_test_t;

   typedef struct packed {
      jtc_test_t test_mode;
      logic [7:0] dev_id;
      logic [3:0] bank_id;
      logic [NUM_LANES-1:0][4:0] lane_id;
      logic scr_en;
      logic [NUM_LANES-1:0] lane_en;
      logic [8:0] frame_octets;
      logic [5:0] mf_frames;
   } jtc_link_cfg_t;

endpackage : jtc_pkg

// file: rtl/jtc_link_cfg.sv
// Transmit link configuration registers, AHB-Lite slave and multiframe phase counter.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
module jtc_link_cfg #(
   parameter int PHASE_W = 12
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Link timing.
   input wire logic sysref,
   output logic [PHASE_W-1:0] mf_phase,
   output logic mf_boundary,
   // Configuration toward the link layer.
   output jtc_pkg::jtc_link_cfg_t link_cfg
);

   // Register file state.
   logic [2:0] test_r, test_nxt;
   logic [4:0] phase_ofs_r, phase_ofs_nxt;
   logic [7:0] dev_id_r, dev_id_nxt;
   logic [3:0] bank_id_r, bank_id_nxt;
   logic [4:0] lane_id_r [jtc_pkg::NUM_LANES];
   logic [4:0] lane_id_nxt [jtc_pkg::NUM_LANES];
   logic scr_r, scr_nxt;
   logic [4:0] lane_code_r, lane_code_nxt;
   logic [7:0] frame_oct_r, frame_oct_nxt;
   logic [4:0] mf_frames_r, mf_frames_nxt;

   // Bus state.
   logic wr_pend_r, wr_pend_nxt;
   logic rd_pend_r, rd_pend_nxt;
   logic [11:0] idx_r, idx_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;

   // SYSREF synchroniser and phase counter state.
   logic [jtc_pkg::SYNC_STAGES-1:0] sref_sync_r, sref_sync_nxt;
   logic sref_level_r, sref_level_nxt;
   logic [PHASE_W-1:0] phase_r, phase_nxt;
   logic boundary_r, boundary_nxt;
   jtc_pkg::jtc_link_cfg_t cfg_r, cfg_nxt;

   logic addr_take;
   logic [PHASE_W-1:0] mf_len;
   logic sref_rise;

   function automatic logic [jtc_pkg::NUM_LANES-1:0] lanes_of(input logic [4:0] code);
      logic [jtc_pkg::NUM_LANES-1:0] en;
      en = '0;
      unique case (code)
         jtc_pkg::LANES_ONE: en = 4'h1;
         jtc_pkg::LANES_TWO: en = 4'h3;
         jtc_pkg::LANES_FOUR: en = 4'hF;
         default: en = 4'hF;
      endcase
      return en;
   endfunction : lanes_of

   // Reserved selector codes fall back to normal traffic.
   function automatic jtc_pkg::jtc_test_t test_of(input logic [2:0] code);
      jtc_pkg::jtc_test_t t;
      t = jtc_pkg::JTC_TEST_NORMAL;
      unique case (code)
         3'b001: t = jtc_pkg::JTC_TEST_D21_5;
         3'b100: t = jtc_pkg::JTC_TEST_RPAT;
         3'b101: t = jtc_pkg::JTC_TEST_JSPAT;
         3'b110: t = jtc_pkg::JTC_TEST_JTSPAT;
         default: t = jtc_pkg::JTC_TEST_NORMAL;
      endcase
      return t;
   endfunction : test_of

   assign addr_take = hsel && hready && (htrans == jtc_pkg::HTRANS_NONSEQ);

   // Bus: writes take no wait state, reads take one so that a read right
   // after a write sees the written value.
   always_comb begin
      wr_pend_nxt = 1'b0;
      rd_pend_nxt = 1'b0;
      idx_nxt = idx_r;
      hrdata_nxt = hrdata_r;
      if (rd_pend_r) begin
         hrdata_nxt = '0;
         unique case (idx_r)
            jtc_pkg::IDX_LINK_TEST: hrdata_nxt[2:0] = test_r;
            jtc_pkg::IDX_PHASE_OFS: hrdata_nxt[4:0] = phase_ofs_r;
            jtc_pkg::IDX_DEV_ID: hrdata_nxt[7:0] = dev_id_r;
            jtc_pkg::IDX_BANK_ID: hrdata_nxt[3:0] = bank_id_r;
            jtc_pkg::IDX_LANE0_ID: hrdata_nxt[4:0] = lane_id_r[0];
            jtc_pkg::IDX_LANE1_ID: hrdata_nxt[4:0] = lane_id_r[1];
            jtc_pkg::IDX_LANE2_ID: hrdata_nxt[4:0] = lane_id_r[2];
            jtc_pkg::IDX_LANE3_ID: hrdata_nxt[4:0] = lane_id_r[3];
            jtc_pkg::IDX_SCR_LANES: begin
               hrdata_nxt[jtc_pkg::SCR_BIT] = scr_r;
               hrdata_nxt[4:0] = lane_code_r;
            end
            jtc_pkg::IDX_FRAME_OCT: hrdata_nxt[7:0] = frame_oct_r;
            jtc_pkg::IDX_MF_FRAMES: hrdata_nxt[4:0] = mf_frames_r;
            default: hrdata_nxt = '0;
         endcase
      end
      if (addr_take && !rd_pend_r) begin
         idx_nxt = (haddr[31:jtc_pkg::ADDR_MSB+1] == '0)
                   ? haddr[jtc_pkg::ADDR_MSB:jtc_pkg::ADDR_LSB] : '0;
         wr_pend_nxt = hwrite;
         rd_pend_nxt = !hwrite;
      end
   end

   assign hreadyout = !rd_pend_r;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // Register writes land in the data phase; only defined field bits are kept.
   always_comb begin
      test_nxt = test_r;
      phase_ofs_nxt = phase_ofs_r;
      dev_id_nxt = dev_id_r;
      bank_id_nxt = bank_id_r;
      lane_id_nxt = lane_id_r;
      scr_nxt = scr_r;
      lane_code_nxt = lane_code_r;
      frame_oct_nxt = frame_oct_r;
      mf_frames_nxt = mf_frames_r;
      if (wr_pend_r) begin
         unique case (idx_r)
            jtc_pkg::IDX_LINK_TEST: test_nxt = hwdata[2:0];
            jtc_pkg::IDX_PHASE_OFS: phase_ofs_nxt = hwdata[4:0];
            jtc_pkg::IDX_DEV_ID: dev_id_nxt = hwdata[7:0];
            jtc_pkg::IDX_BANK_ID: bank_id_nxt = hwdata[3:0];
            jtc_pkg::IDX_LANE0_ID: lane_id_nxt[0] = hwdata[4:0];
            jtc_pkg::IDX_LANE1_ID: lane_id_nxt[1] = hwdata[4:0];
            jtc_pkg::IDX_LANE2_ID: lane_id_nxt[2] = hwdata[4:0];
            jtc_pkg::IDX_LANE3_ID: lane_id_nxt[3] = hwdata[4:0];
            jtc_pkg::IDX_SCR_LANES: begin
               scr_nxt = hwdata[jtc_pkg::SCR_BIT];
               lane_code_nxt = hwdata[4:0];
            end
            jtc_pkg::IDX_FRAME_OCT: frame_oct_nxt = hwdata[7:0];
            jtc_pkg::IDX_MF_FRAMES: mf_frames_nxt = hwdata[4:0];
            default: test_nxt = test_r;
         endcase
      end
   end

   // Multiframe length in core clocks; software keeps F*K a multiple of four.
   assign mf_len = PHASE_W'(((32'(frame_oct_r) + 32'd1) * (32'(mf_frames_r) + 32'd1))
                   / jtc_pkg::OCTETS_PER_CLK);

   // A SYSREF edge counts once the second and third stages agree on high.
   assign sref_rise = sref_sync_r[2] && sref_sync_r[1] && !sref_level_r;

   always_comb begin
      sref_sync_nxt = {sref_sync_r[1:0], sysref};
      sref_level_nxt = sref_level_r;
      if (sref_sync_r[2] == sref_sync_r[1]) begin
         sref_level_nxt = sref_sync_r[2];
      end
      boundary_nxt = 1'b0;
      if (sref_rise) begin
         phase_nxt = PHASE_W'(phase_ofs_r);
      end else if (phase_r + PHASE_W'(1) >= mf_len) begin
         phase_nxt = '0;
         boundary_nxt = 1'b1;
      end else begin
         phase_nxt = phase_r + PHASE_W'(1);
      end
   end

   // Configuration presented to the link layer.
   always_comb begin
      cfg_nxt.test_mode = test_of(test_r);
      cfg_nxt.dev_id = dev_id_r;
      cfg_nxt.bank_id = bank_id_r;
      for (int i = 0; i < jtc_pkg::NUM_LANES; i++) begin
         cfg_nxt.lane_id[i] = lane_id_r[i];
      end
      cfg_nxt.scr_en = scr_r;
      cfg_nxt.lane_en = lanes_of(lane_code_r);
      cfg_nxt.frame_octets = {1'b0, frame_oct_r} + 9'h001;
      cfg_nxt.mf_frames = {1'b0, mf_frames_r} + 6'h01;
   end

   assign link_cfg = cfg_r;
   assign mf_phase = phase_r;
   assign mf_boundary = boundary_r;

   // Bus handshake state; a read holds the bus for exactly one wait state.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         idx_r <= '0;
         hrdata_r <= '0;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         rd_pend_r <= rd_pend_nxt;
         idx_r <= idx_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   // Software-visible configuration fields.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         test_r <= jtc_pkg::RST_LINK_TEST;
         phase_ofs_r <= jtc_pkg::RST_PHASE_OFS;
         dev_id_r <= jtc_pkg::RST_DEV_ID;
         bank_id_r <= jtc_pkg::RST_BANK_ID;
         lane_id_r <= jtc_pkg::RST_LANE_ID;
         scr_r <= jtc_pkg::RST_SCR;
         lane_code_r <= jtc_pkg::RST_LANE_CODE;
         frame_oct_r <= jtc_pkg::RST_FRAME_OCT;
         mf_frames_r <= jtc_pkg::RST_MF_FRAMES;
      end else begin
         test_r <= test_nxt;
         phase_ofs_r <= phase_ofs_nxt;
         dev_id_r <= dev_id_nxt;
         bank_id_r <= bank_id_nxt;
         lane_id_r <= lane_id_nxt;
         scr_r <= scr_nxt;
         lane_code_r <= lane_code_nxt;
         frame_oct_r <= frame_oct_nxt;
         mf_frames_r <= mf_frames_nxt;
      end
   end

   // SYSREF synchroniser, filtered level and multiframe phase counter.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sref_sync_r <= '0;
         sref_level_r <= 1'b0;
         phase_r <= '0;
         boundary_r <= 1'b0;
      end else begin
         sref_sync_r <= sref_sync_nxt;
         sref_level_r <= sref_level_nxt;
         phase_r <= phase_nxt;
         boundary_r <= boundary_nxt;
      end
   end

   // Registered copy of the configuration so the link layer sees clean flops.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_r <= '0;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

endmodule : jtc_link_cfg

// file: verification/jtc_link_cfg_properties.sv
// Port-level assertions for the transmit link configuration block.
`timescale 1ns/100ps
module jtc_link_cfg_properties #(
   parameter int PHASE_W = 12
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Register bus.
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Link side.
   input wire logic [PHASE_W-1:0] mf_phase,
   input wire logic mf_boundary,
   input wire jtc_pkg::jtc_link_cfg_t link_cfg
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire take = hsel && hready && htrans == jtc_pkg::HTRANS_NONSEQ;
   chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   chk_hrdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data moved outside a read");
   chk_boundary_zero: assert property (mf_boundary |-> mf_phase == '0)
      else $error("boundary pulse off phase zero");
   chk_reset_cfg: assert property ($fell(rst) |-> ##[1:2] (link_cfg.scr_en
      && link_cfg.lane_en == 4'hF && link_cfg.dev_id == 8'h00
      && link_cfg.lane_id == {5'h03, 5'h02, 5'h01, 5'h00}
      && link_cfg.frame_octets == 9'h001 && link_cfg.mf_frames == 6'h20))
      else $error("configuration after reset wrong");
   chk_lane_legal: assert property (link_cfg.lane_en != 4'h0 |->
      link_cfg.lane_en inside {4'h1, 4'h3, 4'hF}) else $error("illegal lane set");
   chk_test_legal: assert property (link_cfg.test_mode inside {3'h0, 3'h1, 3'h4, 3'h5, 3'h6})
      else $error("reserved test code reached link");
   chk_rsvd_zero: assert property (hrdata[31:8] == 24'h000000)
      else $error("bits above the register word read nonzero");
   cover property (take && !hwrite);
   cover property (take && hwrite);
   cover property (mf_boundary);
   cover property (link_cfg.test_mode == jtc_pkg::JTC_TEST_JTSPAT);
endmodule : jtc_link_cfg_properties

bind jtc_link_cfg jtc_link_cfg_properties #(.PHASE_W(PHASE_W)) chk_i (.core_clk(core_clk),
   .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mf_phase(mf_phase),
   .mf_boundary(mf_boundary), .link_cfg(link_cfg));

// file: verification/jtc_rx_model.sv
// Behavioural link receiver that issues SYSREF and counts multiframe boundaries.
`timescale 1ns/100ps
module jtc_rx_model (
   // Clock and command.
   input wire logic core_clk,
   input wire logic fire,
   // Link timing.
   input wire logic mf_boundary,
   output logic sysref,
   output int n_boundary
);
   int hold = 0;
   // A request holds SYSREF high for six cycles so the one-shot reload is exercised.
   always @(posedge core_clk) begin
      if (fire)
         hold <= 6;
      else if (hold > 0)
         hold <= hold - 1;
      sysref <= fire || hold > 1;
      n_boundary <= n_boundary + int'(mf_boundary === 1'b1);
   end
endmodule : jtc_rx_model

// file: verification/tb_top.sv
// Self-checking bench for the transmit link configuration block.
`timescale 1ns/100ps
module tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic sysref;
   logic fire = 1'b0;
   logic [11:0] mf_phase;
   logic mf_boundary;
   jtc_pkg::jtc_link_cfg_t link_cfg;
   int n_boundary;
   int fails = 0;
   int n_compared = 0;
   logic [31:0] rd;
   logic [11:0] idx_tab [11] = '{12'h574, 12'h578, 12'h580, 12'h581, 12'h583, 12'h584,
      12'h585, 12'h586, 12'h58B, 12'h58C, 12'h58D};
   logic [31:0] rst_tab [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h2, 32'h3,
      32'h83, 32'h0, 32'h1F};
   logic [31:0] msk_tab [11] = '{32'h7, 32'h1F, 32'hFF, 32'hF, 32'h1F, 32'h1F, 32'h1F,
      32'h1F, 32'h9F, 32'hFF, 32'h1F};
   logic [31:0] lane_w [3] = '{32'h00, 32'h81, 32'h03};
   logic [3:0] lane_e [3] = '{4'h1, 4'h3, 4'hF};
   always #25 core_clk = ~core_clk;
   jtc_link_cfg jtc_link_cfg_i (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(jtc_pkg::HSIZE_WORD), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sysref(sysref), .mf_phase(mf_phase), .mf_boundary(mf_boundary), .link_cfg(link_cfg));
   jtc_rx_model jtc_rx_model_i (.core_clk(core_clk), .fire(fire),
      .mf_boundary(mf_boundary), .sysref(sysref), .n_boundary(n_boundary));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // One single AHB transfer; read data lands in rd.
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {18'h0, idx, 2'b00};
      hwrite <= wr;
      htrans <= jtc_pkg::HTRANS_NONSEQ;
      do @(posedge core_clk); while (hreadyout !== 1'b1 && ++n < 50);
      hsel <= 1'b0;
      htrans <= jtc_pkg::HTRANS_IDLE;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1 && ++n < 100);
      rd = hrdata;
      if (n >= 100)
         fails++;
   endtask : bus
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   initial begin
      #2000000;
      fails++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      for (int i = 0; i < 11; i++) begin
         bus(1'b0, idx_tab[i], 32'h0);
         check(64'(rd), 64'(rst_tab[i]));
      end
      $display("reset values done");
      for (int i = 0; i < 11; i++) begin
         bus(1'b1, idx_tab[i], 32'hFFFFFFFF);
         bus(1'b0, idx_tab[i], 32'h0);
         check(64'(rd), 64'(msk_tab[i]));
      end
      bus(1'b1, 12'h590, 32'hFF);
      bus(1'b0, 12'h590, 32'h0);
      check(64'(rd), 64'h0);
      check(64'(link_cfg), {9'h0, 3'h0, 8'hFF, 4'hF, 20'hFFFFF, 1'b1, 4'hF, 9'h100, 6'h20});
      $display("reserved bits done");
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, jtc_pkg::IDX_LINK_TEST, 32'(c));
         repeat (2) @(posedge core_clk);
         check(64'(link_cfg.test_mode), (c == 2 || c == 3 || c == 7) ? 64'h0 : 64'(c));
      end
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, jtc_pkg::IDX_SCR_LANES, lane_w[k]);
         repeat (2) @(posedge core_clk);
         check(64'({link_cfg.scr_en, link_cfg.lane_en}), 64'({lane_w[k][7], lane_e[k]}));
      end
      $display("modes done");
      // F of four and K of 32 give a 32-clock multiframe.
      bus(1'b1, jtc_pkg::IDX_FRAME_OCT, 32'h3);
      bus(1'b1, jtc_pkg::IDX_PHASE_OFS, 32'h14);
      for (int n = 0; n < 40 && mf_phase !== 12'h0; n++)
         @(posedge core_clk);
      fire <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
      for (int n = 0; n < 10 && mf_phase !== 12'h014; n++)
         @(posedge core_clk);
      check(64'(mf_phase), 64'h14);
      repeat (12) @(posedge core_clk);
      check(64'({mf_boundary, mf_phase}), 64'h1000);
      check(64'(n_boundary != 0), 64'h1);
      $display("phase offset done");
      tally_and_finish();
   end
endmodule : tb_top
